// [fisa_aggregator.sv]
// interrupt status vectors for 31 message fifos and the transmit queue
// Operation
// R01: receive-pending bit is set while any enabled receive condition of its fifo is active
// R02: receive-pending bit is or of enabled receive flags and clears itself
// R03: bit 0 of receive-pending and receive-overflow vectors always reads zero
// R04: receive-overflow vector bits 31..1 show pending overflow per fifo
// R05: overflow bit holds until fifo status flag is cleared; vector writes ignored
// R06: transmit-pending vector is 32 bits, set on any enabled transmit condition
// R07: transmit-pending bit is or of enabled transmit flags, clears automatically
// R08: transmit-pending bit 0 is the transmit queue, others fifo of same index
// R09: transmit-attempt vector, bit 0 is queue, holds until fifo flag cleared
// R10: global receive flag is high while receive-pending vector is nonzero
// R11: global transmit flag is high while transmit-pending vector is nonzero
// R12: all four vectors are read-only, reset to zero, ignore writes
`timescale 1ns/10ps
`default_nettype none
`include "fisa_defs.svh"
module fisa_aggregator #(
  parameter int SLOTS    = `FISA_NUM_SLOTS,
  parameter int RX_FLAGS = 3,
  parameter int TX_FLAGS = 3
) (
  input  wire logic                      mclk,
  input  wire logic                      rst_b,
  input  wire logic [SLOTS*RX_FLAGS-1:0] rx_flags,
  input  wire logic [SLOTS*RX_FLAGS-1:0] rx_enables,
  input  wire logic [SLOTS*TX_FLAGS-1:0] tx_flags,
  input  wire logic [SLOTS*TX_FLAGS-1:0] tx_enables,
  input  wire logic [SLOTS-1:0]          rx_overflow_flags,
  input  wire logic [SLOTS-1:0]          tx_attempt_flags,
  input  wire logic                      reg_rd,
  input  wire logic                      reg_wr,
  input  wire fisa_pkg::fisa_sel_t       reg_sel,
  input  wire logic [SLOTS-1:0]          reg_wdata,
  output logic      [SLOTS-1:0]          reg_rdata,
  output logic      [SLOTS-1:0]          rx_pending_bits,
  output logic      [SLOTS-1:0]          rx_overflow_bits,
  output logic      [SLOTS-1:0]          tx_pending_bits,
  output logic      [SLOTS-1:0]          tx_attempt_bits,
  output logic                           global_rx_flag,
  output logic                           global_tx_flag
);
  import fisa_pkg::*;

  // reduced flags, next values, status registers and the read holding register
  logic [SLOTS-1:0] rx_any;
  logic [SLOTS-1:0] tx_any;
  logic [SLOTS-1:0] rx_mask;
  logic [SLOTS-1:0] rx_pend_next;
  logic [SLOTS-1:0] rx_ovf_next;
  logic [SLOTS-1:0] tx_pend_next;
  logic [SLOTS-1:0] tx_att_next;
  logic [SLOTS-1:0] rx_pend_reg;
  logic [SLOTS-1:0] rx_ovf_reg;
  logic [SLOTS-1:0] tx_pend_reg;
  logic [SLOTS-1:0] tx_att_reg;
  logic [SLOTS-1:0] rdata_next;
  logic [SLOTS-1:0] rdata_reg;
  fisa_state_t      state_reg;
  fisa_state_t      state_next;

  // selects one vector by register index; used only by the read path
  function automatic logic [SLOTS-1:0] pick(input fisa_sel_t s, input logic [SLOTS-1:0] a,
                                            input logic [SLOTS-1:0] b, input logic [SLOTS-1:0] c,
                                            input logic [SLOTS-1:0] d);
    case (s)
      `FISA_SEL_RX_PEND: pick = a;
      `FISA_SEL_RX_OVF:  pick = b;
      `FISA_SEL_TX_PEND: pick = c;
      default:           pick = d;
    endcase
  endfunction

  // per-fifo or of enabled receive and transmit flags
  fisa_or_reduce #(
    .SLOTS (SLOTS),
    .FLAGS (RX_FLAGS)
  ) u_rx_or (
    .flags   (rx_flags),
    .enables (rx_enables),
    .any_set (rx_any)
  );

  // transmit side reuses the same reducer; its slot 0 is the transmit queue
  fisa_or_reduce #(
    .SLOTS (SLOTS),
    .FLAGS (TX_FLAGS)
  ) u_tx_or (
    .flags   (tx_flags),
    .enables (tx_enables),
    .any_set (tx_any)
  );

  // fifo 0 cannot receive, so its receive slot is forced to zero
  assign rx_mask      = SLOTS'(`FISA_RX_UNUSED_MASK);
  assign rx_pend_next = rx_any & rx_mask;               // see R01 see R02 see R03
  assign rx_ovf_next  = rx_overflow_flags & rx_mask;    // see R03 see R04 see R05
  // overflow and attempt mirror the fifo flags, so only clearing the fifo flag drops them
  assign tx_pend_next = tx_any;                         // see R06 see R07 see R08
  assign tx_att_next  = tx_attempt_flags;               // see R09
  assign rdata_next   = pick(reg_sel, rx_pend_reg, rx_ovf_reg, tx_pend_reg, tx_att_reg);
  // state only marks the first edge after reset, so the follow checks skip that edge
  assign state_next   = FISA_LIVE;

  // status vectors; reg_wr and reg_wdata deliberately touch nothing
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_pend_reg <= SLOTS'(`FISA_VEC_RESET);          // see R12
      rx_ovf_reg  <= SLOTS'(`FISA_VEC_RESET);
      tx_pend_reg <= SLOTS'(`FISA_VEC_RESET);
      tx_att_reg  <= SLOTS'(`FISA_VEC_RESET);
      state_reg   <= FISA_IDLE;
    end else begin
      rx_pend_reg <= rx_pend_next;
      rx_ovf_reg  <= rx_ovf_next;
      tx_pend_reg <= tx_pend_next;
      tx_att_reg  <= tx_att_next;
      state_reg   <= state_next;
    end
  end

  // read data registered one cycle after reg_rd
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= SLOTS'(`FISA_VEC_RESET);
    end else if (reg_rd) begin
      rdata_reg <= rdata_next;
    end
  end

  // outputs straight from the registers; the globals are a plain or of the two pending registers
  assign reg_rdata        = rdata_reg;
  assign rx_pending_bits  = rx_pend_reg;
  assign rx_overflow_bits = rx_ovf_reg;
  assign tx_pending_bits  = tx_pend_reg;
  assign tx_attempt_bits  = tx_att_reg;
  assign global_rx_flag   = |rx_pend_reg;               // see R10
  assign global_tx_flag   = |tx_pend_reg;               // see R11

  // receive pending: one cycle behind the enabled flags, slot 0 always clear
  rx_bit0_zero_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R03
    rx_pending_bits[`FISA_SLOT0_BIT] == 1'b0 && rx_overflow_bits[`FISA_SLOT0_BIT] == 1'b0)
    else $error("receive slot 0 not zero");
  rx_pend_follow_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R01
    state_reg == FISA_LIVE |-> rx_pending_bits == ($past(rx_any) & rx_mask))
    else $error("receive pending does not track enabled flags");
  rx_pend_clear_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R02
    (rx_any == '0) |=> rx_pending_bits == '0)
    else $error("receive pending did not self clear");

  // receive overflow: mirrors the fifo-held flag, so only a fifo-side clear drops it
  rx_ovf_track_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R04
    rx_overflow_flags[1] |=> rx_overflow_bits[1])
    else $error("overflow bit not set");
  rx_ovf_follow_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R04
    state_reg == FISA_LIVE |-> rx_overflow_bits == {$past(rx_overflow_flags[SLOTS-1:1]), 1'b0})
    else $error("overflow vector does not mirror fifo flags");
  ovf_hold_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R05
    (rx_overflow_flags[1] && reg_wr) ##1 rx_overflow_flags[1] |=> rx_overflow_bits[1])
    else $error("overflow bit cleared by write");
  rx_ovf_clear_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R05
    $fell(rx_overflow_flags[5]) |=> !rx_overflow_bits[5])
    else $error("overflow bit outlived its fifo flag");

  // transmit pending: bit 0 is the queue, the rest are fifos of the same index
  tx_pend_follow_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R06
    state_reg == FISA_LIVE |-> tx_pending_bits == $past(tx_any))
    else $error("transmit pending mismatch");
  tx_pend_clear_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R07
    $fell(tx_any[0]) |=> !tx_pending_bits[0])
    else $error("transmit queue pending stuck");
  tx_queue_bit_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R08
    (tx_flags[0] && tx_enables[0]) |=> tx_pending_bits[0])
    else $error("transmit queue not on bit 0");

  // transmit attempt: held by the fifo flag, never by this block
  tx_att_track_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R09
    tx_attempt_flags[0] [*2] |-> tx_attempt_bits[0])
    else $error("attempt bit dropped");
  tx_att_follow_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R09
    state_reg == FISA_LIVE |-> tx_attempt_bits == $past(tx_attempt_flags))
    else $error("attempt vector does not mirror fifo flags");
  tx_att_clear_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R09
    $fell(tx_attempt_flags[0]) |=> !tx_attempt_bits[0])
    else $error("queue attempt bit outlived its flag");

  // global flags: worked from the or-tree outputs rx_any and tx_any, not the raw slot flags
  glob_rx_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R10
    state_reg == FISA_LIVE |-> global_rx_flag == ($past(rx_any[SLOTS-1:1]) != '0))
    else $error("global receive flag wrong");
  glob_tx_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R11
    $rose(global_tx_flag) |-> $past(tx_any != '0))
    else $error("global transmit flag without cause");
  glob_tx_level_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R11
    state_reg == FISA_LIVE |-> global_tx_flag == ($past(tx_any) != '0))
    else $error("global transmit flag does not follow pending");

  // read port: the selected vector as it stood at the read edge; writes change nothing
  read_data_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R01
    reg_rd && reg_sel == `FISA_SEL_RX_PEND |=> reg_rdata == $past(rx_pending_bits))
    else $error("read of receive pending wrong");
  rd_rx_ovf_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R04
    reg_rd && reg_sel == `FISA_SEL_RX_OVF |=> reg_rdata == $past(rx_overflow_bits))
    else $error("read of receive overflow wrong");
  rd_tx_pend_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R06
    reg_rd && reg_sel == `FISA_SEL_TX_PEND |=> reg_rdata == $past(tx_pending_bits))
    else $error("read of transmit pending wrong");
  rd_tx_att_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R09
    reg_rd && reg_sel == `FISA_SEL_TX_ATT |=> reg_rdata == $past(tx_attempt_bits))
    else $error("read of transmit attempt wrong");
  rdata_hold_a: assert property (@(posedge mclk) disable iff (!rst_b) // see R12
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  // main scenarios worth seeing at least once
  rx_seen_c:  cover property (@(posedge mclk) disable iff (!rst_b) $rose(global_rx_flag));
  tx_seen_c:  cover property (@(posedge mclk) disable iff (!rst_b) $rose(global_tx_flag));
  ovf_seen_c: cover property (@(posedge mclk) disable iff (!rst_b) $fell(rx_overflow_bits[5]));
  wr_seen_c:  cover property (@(posedge mclk) disable iff (!rst_b) reg_wr && tx_attempt_bits != '0);
  q_att_c:    cover property (@(posedge mclk) disable iff (!rst_b) $fell(tx_attempt_bits[0]));
endmodule // fisa_aggregator
`default_nettype wire

// [fisa_defs.svh]
// constants for the fifo interrupt status aggregator
`ifndef FISA_DEFS_SVH
`define FISA_DEFS_SVH
`define FISA_NUM_SLOTS      32
`define FISA_SEL_W          2
`define FISA_SEL_RX_PEND    2'h0
`define FISA_SEL_RX_OVF     2'h1
`define FISA_SEL_TX_PEND    2'h2
`define FISA_SEL_TX_ATT     2'h3
`define FISA_VEC_RESET      32'h0000_0000
`define FISA_RX_UNUSED_MASK 32'hffff_fffe
`define FISA_SLOT0_BIT      0
`endif

// [fisa_pkg.sv]
// types for the fifo interrupt status aggregator
`include "fisa_defs.svh"
package fisa_pkg;
  typedef logic [`FISA_NUM_SLOTS-1:0] fisa_vec_t;
  typedef logic [`FISA_SEL_W-1:0]     fisa_sel_t;
  typedef enum logic [1:0] {
    FISA_IDLE = 2'b00,
    FISA_LIVE = 2'b01
  } fisa_state_t;
endpackage

// [fisa_or_reduce.sv]
// per-slot or of enabled flags
`timescale 1ns/10ps
`default_nettype none
module fisa_or_reduce #(
  parameter int SLOTS = 32,
  parameter int FLAGS = 3
) (
  input  wire logic [SLOTS*FLAGS-1:0] flags,
  input  wire logic [SLOTS*FLAGS-1:0] enables,
  output logic      [SLOTS-1:0]       any_set
);
  // a slot is pending when any of its enabled flags is high
  genvar g;
  generate
    for (g = 0; g < SLOTS; g = g + 1) begin : g_slot
      assign any_set[g] = |(flags[g*FLAGS +: FLAGS] & enables[g*FLAGS +: FLAGS]);
    end
  endgenerate
endmodule // fisa_or_reduce
`default_nettype wire

// [test_fifo_interrupt_status_aggregator.sv]
// self-checking bench for the fifo interrupt status aggregator
`timescale 1ns/10ps
`default_nettype none
module test_fifo_interrupt_status_aggregator;
  import fisa_pkg::*;
  logic        mclk, rst_b, reg_rd, reg_wr, grx, gtx;
  logic [95:0] rx_flags, rx_enables, tx_flags, tx_enables;
  logic [31:0] rx_ovf, tx_att, reg_wdata, reg_rdata, rxp, rxo, txp, txa;
  fisa_sel_t   reg_sel;
  int          n_errors, comparisons;

  fisa_aggregator dut (.mclk(mclk), .rst_b(rst_b), .rx_flags(rx_flags), .rx_enables(rx_enables),
    .tx_flags(tx_flags), .tx_enables(tx_enables), .rx_overflow_flags(rx_ovf), .tx_attempt_flags(tx_att),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rx_pending_bits(rxp), .rx_overflow_bits(rxo), .tx_pending_bits(txp), .tx_attempt_bits(txa),
    .global_rx_flag(grx), .global_tx_flag(gtx));

  // 40 ns clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // inputs always move 1 ns after the edge, never on it
  task automatic step();
    @(posedge mclk);
    #1;
  endtask

  // back-to-back reads of all four vectors with a write held alongside
  task automatic rd_all(input logic [31:0] e0, e1, e2, e3);
    logic [31:0] e [4];
    e = '{e0, e1, e2, e3};
    reg_rd = 1'b1;
    reg_wr = 1'b1;
    reg_wdata = 32'hffff_ffff; // all ones, so a write-to-clear slip would show
    for (int s = 0; s < 4; s++) begin
      reg_sel = fisa_sel_t'(s);
      step();
      check("reg_rdata", reg_rdata, e[s]);
    end
    reg_rd = 1'b0;
    reg_wr = 1'b0;
  endtask

  // reset held across an edge with every input but reg_rd and reg_wr active must still show zeros
  task automatic t_reset();
    rx_flags = '1; rx_enables = '1; tx_flags = '1; tx_enables = '1; rx_ovf = '1; tx_att = '1;
    rst_b = 1'b0;
    step();
    check("reset vectors", rxp | rxo | txp | txa | reg_rdata, 32'h0000_0000);
    check("reset globals", {30'h0, grx, gtx}, 32'h0000_0000);
    rx_flags = '0; rx_enables = '0; tx_flags = '0; tx_enables = '0; rx_ovf = '0; tx_att = '0;
    rst_b = 1'b1;
    step();
    rd_all(32'h0, 32'h0, 32'h0, 32'h0);
    $display("test reset done");
  endtask

  // one fifo at a time: one enabled active flag, a disabled active flag next door
  task automatic t_pending(input bit tx);
    for (int g = 0; g < 32; g++) begin
      rx_flags = '0; rx_enables = '0; tx_flags = '0; tx_enables = '0;
      if (tx) begin
        tx_flags[g*3 + g%3] = 1'b1;
        tx_enables[g*3 +: 3] = 3'h7;
        tx_flags[((g+1)%32)*3] = 1'b1;
      end else begin
        rx_flags[g*3 + g%3] = 1'b1;
        rx_enables[g*3 +: 3] = 3'h7;
        rx_flags[((g+1)%32)*3] = 1'b1;
      end
      step();
      if (tx) begin
        check("tx_pending_bits", txp, 32'h1 << g);
        check("global_tx_flag", {31'h0, gtx}, 32'h1);
      end else begin
        check("rx_pending_bits", rxp, (g == 0) ? 32'h0 : 32'h1 << g);
        check("global_rx_flag", {31'h0, grx}, {31'h0, g != 0});
      end
    end
    rx_flags = '0; tx_flags = '0;
    step();
    check("pending cleared", rxp | txp, 32'h0000_0000);
    check("globals cleared", {30'h0, grx, gtx}, 32'h0000_0000);
    $display("test pending done");
  endtask

  // sticky vectors follow the fifo flags only; register writes never clear them
  task automatic t_sticky();
    rx_ovf = 32'hffff_ffff;
    tx_att = 32'ha5a5_5a5a;
    rx_flags[5*3+1] = 1'b1;
    rx_enables[5*3+1] = 1'b1;
    step();
    check("rx_overflow_bits", rxo, 32'hffff_fffe);
    check("tx_attempt_bits", txa, 32'ha5a5_5a5a);
    rd_all(32'h0000_0020, 32'hffff_fffe, 32'h0, 32'ha5a5_5a5a);
    check("overflow after write", rxo, 32'hffff_fffe);
    rx_ovf = 32'h0000_0003;
    tx_att = 32'h0000_0001;
    step();
    check("overflow cleared", rxo, 32'h0000_0002);
    check("attempt queue bit", txa, 32'h0000_0001);
    rx_ovf = 32'h0000_0000;
    tx_att = 32'h0000_0000;
    step();
    check("sticky cleared", rxo | txa, 32'h0000_0000);
    $display("test sticky done");
  endtask

  task automatic end_sim();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // main sequence, then a second reset with everything but reg_rd and reg_wr active
  initial begin
    n_errors = 0; comparisons = 0;
    reg_rd = 1'b0; reg_wr = 1'b0; reg_sel = fisa_sel_t'(0); reg_wdata = 32'hffff_ffff;
    rst_b = 1'b0;
    rx_flags = '0; rx_enables = '0; tx_flags = '0; tx_enables = '0; rx_ovf = '0; tx_att = '0;
    repeat (3) step();
    rst_b = 1'b1;
    step();
    t_pending(1'b0);
    t_pending(1'b1);
    t_sticky();
    t_reset();
    end_sim();
  end

  // hang guard
  initial begin
    #1ms;
    n_errors++;
    end_sim();
  end
endmodule // test_fifo_interrupt_status_aggregator
`default_nettype wire
